// *** design/occ_channel.sv ***
// Purpose: One output compare channel with APB registers and interrupt
// Assumes: Timer counts come from logic on pclk; fault pin is asynchronous
// Notes:   Zero wait state APB; compare matches fire once per count change
import occ_pkg::*;

module occ_channel
  import occ_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Time bases and system state
  input  wire logic [15:0] first_timebase_count,
  input  wire logic [15:0] second_timebase_count,
  input  wire logic        cpu_idle,
  // Pins
  input  wire logic        fault_input_a_n,
  input  wire logic        gpio_level,
  output logic             compare_output_pin,
  output logic             compare_output_oe,
  output logic             irq
);

  // Byte lane mask over the 16-bit registers
  function automatic logic [15:0] occ_lanes(input logic [3:0] s);
    occ_lanes = {{8{s[1]}}, {8{s[0]}}};
  endfunction

  // Registers
  logic [15:0]        ctrl_q, ctrl_d;        // Writable control bits
  logic [15:0]        pri_q, sec_q;          // Compare values
  logic [OCC_NEV-1:0] stat_q, stat_d;        // Sticky events
  logic [OCC_NEV-1:0] en_q;                  // Event enables
  logic [15:0]        cnt_prev_q;            // Last selected count
  logic               out_q, out_d;          // Compare output level
  logic               done_q, done_d;        // One pulse already given
  logic               flt_q, flt_d;          // pwm_fault_status
  logic               flt_prev_q;            // Last synchronised fault level
  logic [31:0]        rdata_d;               // Read mux

  // Bus decode
  wire        setup   = psel & ~penable;
  wire        wr      = psel & penable & pwrite;
  wire        hit_ctl = (paddr == OCC_OFS_CTRL);
  wire        hit_pri = (paddr == OCC_OFS_PRI);
  wire        hit_sec = (paddr == OCC_OFS_SEC);
  wire        hit_clr = (paddr == OCC_OFS_CLR);
  wire        hit_en  = (paddr == OCC_OFS_EN);
  wire        hit_any = hit_ctl | hit_pri | hit_sec | hit_clr | hit_en
                        | (paddr == OCC_OFS_STAT);
  wire [15:0] lanes   = occ_lanes(pstrb);
  wire [15:0] wmask   = OCC_CTRL_WMASK & lanes;

  // Control fields
  wire        idle_halt_select = ctrl_q[OCC_B_IDLE];
  wire        timebase_select  = ctrl_q[OCC_B_TSEL];
  occ_mode_e  mode, new_mode;
  assign mode     = occ_mode_e'(ctrl_q[OCC_MODE_W-1:0]);
  assign new_mode = occ_mode_e'(pwdata[OCC_MODE_W-1:0]);
  // A mode write restarts the channel; timer should be stopped first
  wire        mode_wr = wr & hit_ctl & pstrb[0];

  // Fault pin, synchronised before any logic sees it
  logic fault_s;
  occ_sync #(.RST_VAL(1'b1)) i_occ_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (fault_input_a_n),
    .sync_out (fault_s)
  );

  // Count source and match events
  wire [15:0] cnt    = timebase_select ? second_timebase_count
                                       : first_timebase_count;
  wire        run    = ~(idle_halt_select & cpu_idle);
  wire        tick   = (cnt != cnt_prev_q);
  wire        m_pri  = run & tick & (cnt == pri_q);
  wire        m_sec  = run & tick & (cnt == sec_q);
  wire        m_zero = run & tick & (cnt == OCC_ZERO16);
  wire        pri_nz = (pri_q != OCC_ZERO16);
  wire        flt_on = (mode == OCC_PWMF) & ~fault_s;
  wire        flt_fe = run & (mode == OCC_PWMF) & flt_prev_q & ~fault_s;

  // Output engine; a mode write sets the starting level
  always_comb begin
    out_d  = out_q;
    done_d = done_q;
    if (mode_wr) begin
      done_d = 1'b0;
      case (new_mode)
        OCC_ONE_LO: out_d = 1'b0;
        OCC_ONE_HI: out_d = 1'b1;
        OCC_DELAY:  out_d = 1'b0;
        OCC_CONT:   out_d = 1'b0;
        OCC_PWM,
        OCC_PWMF:   out_d = pri_nz;
        default:    out_d = out_q;   // Toggle keeps level, off is idle
      endcase
    end else begin
      case (mode)
        OCC_ONE_LO: if (m_pri) out_d = 1'b1;
        OCC_ONE_HI: if (m_pri) out_d = 1'b0;
        OCC_TOGGLE: if (m_pri) out_d = ~out_q;
        OCC_DELAY: begin
          // Second match ends the only pulse
          if (!done_q && m_pri) out_d = 1'b1;
          if (!done_q && m_sec) begin
            out_d  = 1'b0;
            done_d = 1'b1;
          end
        end
        OCC_CONT: begin
          if (m_pri) out_d = 1'b1;
          if (m_sec) out_d = 1'b0;
        end
        OCC_PWM, OCC_PWMF: begin
          // Period starts at count zero, duty ends at primary match
          if (m_zero) out_d = pri_nz;
          if (m_pri) out_d = 1'b0;
          // A halted channel must not move the pin, fault or not
          if (run && (flt_q || flt_on)) out_d = 1'b0;
        end
        default: out_d = out_q;
      endcase
    end
  end

  // Fault flag: set wins; cleared only by hardware
  always_comb begin
    flt_d = flt_q;
    if (mode != OCC_PWMF) flt_d = 1'b0;
    else if (m_zero && fault_s) flt_d = 1'b0;
    if (run && flt_on) flt_d = 1'b1;
  end

  // Output edges feed the event per mode
  wire rise = run & ~mode_wr & out_d & ~out_q;
  wire fall = run & ~mode_wr & ~out_d & out_q;
  wire ev_edge = ((mode == OCC_ONE_LO) & rise)
               | (((mode == OCC_ONE_HI) | (mode == OCC_DELAY) | (mode == OCC_CONT)) & fall)
               | ((mode == OCC_TOGGLE) & (rise | fall));
  wire [OCC_NEV-1:0] ev  = {flt_fe, ev_edge};
  wire [OCC_NEV-1:0] clr = (wr & hit_clr) ? pwdata[OCC_NEV-1:0] : OCC_EV_RST;

  // Status: a new event beats a clear in the same cycle
  assign stat_d = (stat_q & ~clr) | ev;

  // Control write keeps unimplemented bits at zero
  assign ctrl_d = (wr & hit_ctl) ? ((ctrl_q & ~wmask) | (pwdata[15:0] & wmask))
                                 : ctrl_q;

  // Read mux
  always_comb begin
    rdata_d = OCC_ZERO32;
    if (hit_ctl) rdata_d[15:0] = (ctrl_q & OCC_CTRL_WMASK)
                               | ({15'h0000, flt_q} << OCC_B_FLT);
    else if (hit_pri) rdata_d[15:0] = pri_q;
    else if (hit_sec) rdata_d[15:0] = sec_q;
    else if (paddr == OCC_OFS_STAT) rdata_d[OCC_NEV-1:0] = stat_q;
    else if (hit_en) rdata_d[OCC_NEV-1:0] = en_q;
  end

  // Bus answers: no wait states, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign irq     = |(stat_q & en_q);

  // Register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= OCC_CTRL_RST;
      pri_q  <= OCC_CMP_RST;
      sec_q  <= OCC_CMP_RST;
      en_q   <= OCC_EV_RST;
      stat_q <= OCC_EV_RST;
      prdata <= OCC_ZERO32;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      if (wr && hit_pri) pri_q <= (pri_q & ~lanes) | (pwdata[15:0] & lanes);
      if (wr && hit_sec) sec_q <= (sec_q & ~lanes) | (pwdata[15:0] & lanes);
      if (wr && hit_en && pstrb[0]) en_q <= pwdata[OCC_NEV-1:0];
      // Read data captured in setup, held through access
      if (setup) prdata <= pwrite ? OCC_ZERO32 : rdata_d;
    end
  end

  // Compare engine state and pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_prev_q         <= OCC_ZERO16;
      out_q              <= 1'b0;
      done_q             <= 1'b0;
      flt_q              <= 1'b0;
      flt_prev_q         <= 1'b1;
      compare_output_pin <= 1'b0;
      compare_output_oe  <= 1'b0;
    end else begin
      if (run) cnt_prev_q <= cnt;  // Halted channel sees no ticks
      out_q      <= out_d;
      done_q     <= done_d;
      flt_q      <= flt_d;
      flt_prev_q <= fault_s;
      // Disabled channel passes the port level through
      compare_output_oe  <= (mode != OCC_OFF);
      compare_output_pin <= (mode != OCC_OFF) ? out_d : gpio_level;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_idle;
    (idle_halt_select && cpu_idle && !mode_wr) |=> $stable(out_q);
  endproperty
  a_idle: assert property (p_idle) else $error("output moved while halted");

  property p_flt_set;
    (mode == OCC_PWMF && !fault_s && run && !mode_wr) |=> flt_q;
  endproperty
  a_flt_set: assert property (p_flt_set) else $error("fault not flagged");

  property p_flt_mode;
    (mode != OCC_PWMF) |=> !flt_q;
  endproperty
  a_flt_mode: assert property (p_flt_mode) else $error("fault flag outside 111");

  property p_tsel;
    (timebase_select && mode == OCC_ONE_LO && run && !mode_wr
     && second_timebase_count == pri_q && second_timebase_count != cnt_prev_q)
    |=> out_q;
  endproperty
  a_tsel: assert property (p_tsel) else $error("second timer not used");

  property p_pwm_nf;
    (mode == OCC_PWM && !mode_wr) |=> !flt_q && !$rose(stat_q[OCC_EV_EDGE]);
  endproperty
  a_pwm_nf: assert property (p_pwm_nf) else $error("PWM 110 reacted");

  property p_cont;
    (mode == OCC_CONT && m_sec && !mode_wr) |=> !out_q;
  endproperty
  a_cont: assert property (p_cont) else $error("pulse not ended");

  property p_delay;
    (mode == OCC_DELAY && done_q && !mode_wr) |=> $stable(out_q);
  endproperty
  a_delay: assert property (p_delay) else $error("second pulse given");

  property p_toggle;
    (mode == OCC_TOGGLE && m_pri && !mode_wr) |=> out_q != $past(out_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed");

  property p_init_hi;
    (mode_wr && new_mode == OCC_ONE_HI) |=> out_q ##1 compare_output_pin;
  endproperty
  a_init_hi: assert property (p_init_hi) else $error("mode 010 not high");

  property p_rsvd;
    (psel && penable && !pwrite && hit_ctl) |-> (prdata[31:0] & ~{16'h0000,
      OCC_CTRL_RMASK}) == OCC_ZERO32;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  property p_gpio;
    (mode == OCC_OFF) |=> compare_output_pin == $past(gpio_level) && !compare_output_oe;
  endproperty
  a_gpio: assert property (p_gpio) else $error("pin not released");

  c_fault:  cover property (flt_fe ##1 irq);
  c_pwm:    cover property (mode == OCC_PWM && m_zero ##[1:50] m_pri);
  c_single: cover property (mode == OCC_DELAY && m_sec && !done_q);

endmodule

// *** design/occ_sync.sv ***
// Purpose: Two-flop synchroniser for a level arriving from a pin
// Assumes: Input is asynchronous to pclk
// Notes:   Only the second flop may be read by other logic
module occ_sync
  import occ_pkg::*;
#(
  parameter logic RST_VAL = 1'b1  // Level shown during reset
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;  // First stage, read only by the second stage

  // Two stages; a constant on reset, never the pin itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// *** pkg/occ_pkg.sv ***
// Purpose: Shared constants and types for the output compare channel
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Control register keeps its 16-bit layout in the low half of the word
package occ_pkg;

  // Register byte offsets
  localparam logic [7:0] OCC_OFS_CTRL = 8'h00;  // compare_channel_control
  localparam logic [7:0] OCC_OFS_PRI  = 8'h04;  // primary_compare_value
  localparam logic [7:0] OCC_OFS_SEC  = 8'h08;  // secondary compare value
  localparam logic [7:0] OCC_OFS_STAT = 8'h0C;  // sticky event status, read only
  localparam logic [7:0] OCC_OFS_CLR  = 8'h10;  // event clear, write only
  localparam logic [7:0] OCC_OFS_EN   = 8'h14;  // event enable

  // Control register field positions
  localparam int unsigned OCC_B_IDLE = 13;  // idle_halt_select
  localparam int unsigned OCC_B_FLT  = 4;   // pwm_fault_status
  localparam int unsigned OCC_B_TSEL = 3;   // timebase_select
  localparam int unsigned OCC_MODE_W = 3;   // compare_mode_field width

  // Writable control bits; all others except pwm_fault_status read as zero
  localparam logic [15:0] OCC_CTRL_WMASK = 16'h200F;
  // Every implemented control bit, as seen by a read
  localparam logic [15:0] OCC_CTRL_RMASK = 16'h201F;

  // Reset values
  localparam logic [15:0] OCC_CTRL_RST = 16'h0000;
  localparam logic [15:0] OCC_CMP_RST  = 16'h0000;
  localparam logic [15:0] OCC_ZERO16   = 16'h0000;
  localparam logic [31:0] OCC_ZERO32   = 32'h0000_0000;

  // Event status bits
  localparam int unsigned OCC_NEV     = 2;
  localparam int unsigned OCC_EV_EDGE = 0;  // output edge event
  localparam int unsigned OCC_EV_FLT  = 1;  // fault falling edge event
  localparam logic [OCC_NEV-1:0] OCC_EV_RST = 2'h0;

  // Compare modes
  typedef enum logic [OCC_MODE_W-1:0] {
    OCC_OFF    = 3'b000,  // Disabled, pin back to port logic
    OCC_ONE_LO = 3'b001,  // Start low, match drives high
    OCC_ONE_HI = 3'b010,  // Start high, match drives low
    OCC_TOGGLE = 3'b011,  // Match inverts the pin
    OCC_DELAY  = 3'b100,  // Start low, one pulse
    OCC_CONT   = 3'b101,  // Start low, pulse train
    OCC_PWM    = 3'b110,  // PWM, fault ignored
    OCC_PWMF   = 3'b111   // PWM, fault honoured
  } occ_mode_e;

endpackage

// *** test/occ_channel_test.sv ***
// Purpose: Self-checking bench for the output compare channel over APB
// Assumes: Timer counts held still while control is written
// Notes:   Counts are stepped by hand, one value per clock
module occ_channel_test;
  import occ_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        pclk, presetn, psel, penable, pwrite, cpu_idle, gpio_level, fault_on;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] tb1, tb2;
  logic        pready, pslverr, rerr, pin, oe, irq, flt_n, pad;
  logic [7:0]  rise_cnt, fall_cnt, f0, r0;
  int          miscompares, n_tests;

  occ_channel i_occ_channel (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_timebase_count(tb1),
    .second_timebase_count(tb2), .cpu_idle(cpu_idle), .fault_input_a_n(flt_n),
    .gpio_level(gpio_level), .compare_output_pin(pin), .compare_output_oe(oe), .irq(irq));

  occ_ext_load i_occ_ext_load (.pclk(pclk), .compare_output_pin(pin),
    .compare_output_oe(oe), .gpio_level(gpio_level), .fault_on(fault_on),
    .fault_input_a_n(flt_n), .pad_level(pad), .rise_cnt(rise_cnt), .fall_cnt(fall_cnt));

  // Free-running bus clock
  always #50 pclk = ~pclk;

  // Comparison with a mismatch line on failure
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) miscompares++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk("read", rdat, exp);
  endtask

  // Step one time base through 0..n-1, then let the pin settle
  task automatic run(input logic sel, input int n);
    for (int v = 0; v < n; v++) begin
      @(posedge pclk);
      if (sel) tb2 <= 16'(v);
      else tb1 <= 16'(v);
    end
    repeat (4) @(posedge pclk);
  endtask

  task automatic pin_is(input logic e);
    chk("pin", 32'(pin), 32'(e));
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    report_and_stop;
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0000_0000; tb1 = 16'h0000; tb2 = 16'h0000; cpu_idle = 0;
    gpio_level = 0; fault_on = 0; miscompares = 0; n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state, masked control bits, unmapped place
    rd(OCC_OFS_CTRL, 32'h0000_0000);
    rd(OCC_OFS_STAT, 32'h0000_0000);
    chk("irq", 32'(irq), 32'h0000_0000);
    wr(OCC_OFS_CTRL, 32'h0000_FFFF);
    rd(OCC_OFS_CTRL, 32'h0000_200F);
    wr(OCC_OFS_CTRL, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    chk("slverr", 32'(rerr), 32'h0000_0001);
    $display("test registers done");
    // One-shot high with interrupt; timer held still during writes
    wr(OCC_OFS_PRI, 32'h0000_0005);
    cpu_idle <= 1'b1;
    wr(OCC_OFS_CTRL, 32'h0000_0001);
    wr(OCC_OFS_CLR, 32'h0000_0003);
    wr(OCC_OFS_EN, 32'h0000_0001);
    pin_is(1'b0);
    chk("oe", 32'(oe), 32'h0000_0001);
    run(1'b0, 10);
    pin_is(1'b1);
    chk("irq", 32'(irq), 32'h0000_0001);
    wr(OCC_OFS_EN, 32'h0000_0000);
    chk("irq", 32'(irq), 32'h0000_0000);
    wr(OCC_OFS_EN, 32'h0000_0001);
    wr(OCC_OFS_CLR, 32'h0000_0001);
    chk("irq", 32'(irq), 32'h0000_0000);
    $display("test one-shot done");
    // Idle halt freezes, then resumes
    wr(OCC_OFS_CTRL, 32'h0000_0000);
    wr(OCC_OFS_CTRL, 32'h0000_2001);
    run(1'b0, 10);
    pin_is(1'b0);
    cpu_idle <= 1'b0;
    run(1'b0, 10);
    pin_is(1'b1);
    // Second time base, start-low then start-high one-shot
    wr(OCC_OFS_CTRL, 32'h0000_0009);
    pin_is(1'b0);
    run(1'b1, 10);
    pin_is(1'b1);
    wr(OCC_OFS_CTRL, 32'h0000_000A);
    pin_is(1'b1);
    run(1'b0, 10);
    pin_is(1'b1);
    run(1'b1, 10);
    pin_is(1'b0);
    // Toggle keeps the level then inverts per match
    wr(OCC_OFS_CTRL, 32'h0000_0003);
    pin_is(1'b0);
    run(1'b0, 10);
    pin_is(1'b1);
    run(1'b0, 10);
    pin_is(1'b0);
    $display("test idle, timebase, toggle done");
    // Single pulse versus pulse train over two periods
    wr(OCC_OFS_SEC, 32'h0000_0008);
    for (int m = 4; m < 6; m++) begin
      wr(OCC_OFS_CTRL, 32'h0000_0000);
      wr(OCC_OFS_CTRL, 32'(m));
      f0 = fall_cnt;
      r0 = rise_cnt;
      run(1'b0, 10);
      run(1'b0, 10);
      chk("pulses", 32'(fall_cnt - f0), (m == 4) ? 32'h0000_0001 : 32'h0000_0002);
      chk("rises", 32'(rise_cnt - r0), (m == 4) ? 32'h0000_0001 : 32'h0000_0002);
      pin_is(1'b0);
    end
    $display("test pulses done");
    // PWM start levels and fault handling
    wr(OCC_OFS_CTRL, 32'h0000_0000);
    wr(OCC_OFS_PRI, 32'h0000_0000);
    wr(OCC_OFS_CTRL, 32'h0000_0006);
    pin_is(1'b0);
    wr(OCC_OFS_CTRL, 32'h0000_0000);
    wr(OCC_OFS_PRI, 32'h0000_0005);
    wr(OCC_OFS_CTRL, 32'h0000_0006);
    pin_is(1'b1);
    fault_on <= 1'b1;
    repeat (6) @(posedge pclk);
    pin_is(1'b1);
    rd(OCC_OFS_CTRL, 32'h0000_0006);
    // One period with the fault still asserted: duty ends at the primary match
    f0 = fall_cnt;
    run(1'b0, 10);
    chk("pwm falls", 32'(fall_cnt - f0), 32'h0000_0001);
    pin_is(1'b0);
    fault_on <= 1'b0;
    wr(OCC_OFS_CTRL, 32'h0000_0007);
    wr(OCC_OFS_CLR, 32'h0000_0003);
    pin_is(1'b1);
    fault_on <= 1'b1;
    repeat (6) @(posedge pclk);
    pin_is(1'b0);
    rd(OCC_OFS_CTRL, 32'h0000_0017);
    rd(OCC_OFS_STAT, 32'h0000_0002);
    wr(OCC_OFS_CTRL, 32'h0000_0007);
    rd(OCC_OFS_CTRL, 32'h0000_0017);
    fault_on <= 1'b0;
    wr(OCC_OFS_CTRL, 32'h0000_0006);
    rd(OCC_OFS_CTRL, 32'h0000_0006);
    $display("test pwm done");
    // Disabled channel gives the pad back to port logic
    wr(OCC_OFS_CTRL, 32'h0000_0000);
    gpio_level <= 1'b1;
    run(1'b0, 10);
    chk("oe", 32'(oe), 32'h0000_0000);
    chk("pad", 32'(pad), 32'h0000_0001);
    $display("test disabled done");
    report_and_stop;
  end
endmodule

// *** test/occ_ext_load.sv ***
// Purpose: Far-side load that watches the compare pin and owns the fault pin
// Assumes: Port logic drives the pad level while the channel output is off
// Notes:   Fault pin idles high through a pull-up; edges counted on pad level
module occ_ext_load (
  // Clock
  input  wire logic       pclk,
  // Pad side of the channel
  input  wire logic       compare_output_pin,
  input  wire logic       compare_output_oe,
  input  wire logic       gpio_level,
  // Fault request from the bench
  input  wire logic       fault_on,
  output logic            fault_input_a_n,
  // Observed pad state
  output logic            pad_level,
  output logic [7:0]      rise_cnt,
  output logic [7:0]      fall_cnt
);
  timeunit 1ns;
  timeprecision 100ps;

  logic pad_prev;  // Pad level one clock ago

  // Pad follows port logic when the channel lets go of it
  assign pad_level = compare_output_oe ? compare_output_pin : gpio_level;
  // Pull-up keeps the fault line inactive unless asked
  assign fault_input_a_n = fault_on ? 1'b0 : 1'b1;

  initial begin
    rise_cnt = 8'h00;
    fall_cnt = 8'h00;
    pad_prev = 1'b0;
  end

  // Edge counting on the visible pad level
  always @(posedge pclk) begin
    if (pad_level === 1'b1 && pad_prev === 1'b0) rise_cnt <= rise_cnt + 8'h01;
    if (pad_level === 1'b0 && pad_prev === 1'b1) fall_cnt <= fall_cnt + 8'h01;
    pad_prev <= pad_level;
  end
endmodule
